// ==== verilog/qwd_decoder.sv ====
`default_nettype none
`include "qwd_defs.svh"

module qwd_decoder (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           sclk,
    input  wire logic           cs_n,
    input  wire logic           sdi,
    output logic                sdo_out,
    output logic                sdo_oe_n,
    output qwd_pkg::qwd_wipers_t wiper_register,
    output logic                latched_output_one,
    output logic                latched_output_two,
    output logic                read_prog_state
);
    import qwd_pkg::*;

    localparam int FB = `QWD_FRAME_BITS;
    localparam int CB = `QWD_CNT_BITS;
    localparam int PB = `QWD_POS_BITS;
    localparam int NW = `QWD_NUM_WIPERS;
    localparam int ND = `QWD_NV_DEPTH;

    function automatic logic [CB-1:0] bin2gray(input logic [CB-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    function automatic logic [CB-1:0] gray2bin(input logic [CB-1:0] g);
        logic [CB-1:0] b;
        b = '0;
        for (int i = CB - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == CB - 1) ? 1'b0 : b[i+1]);
        end
        gray2bin = b;
    endfunction

    function automatic logic [`QWD_NV_BITS-1:0] nv_reset(input int idx);
        if (idx < NW) begin
            nv_reset = `QWD_NV_WIPER_RST;
        end else if (idx == int'(`QWD_NV_OUT_ADDR)) begin
            nv_reset = `QWD_NV_OUT_RST;
        end else begin
            nv_reset = `QWD_NV_USER_RST;
        end
    endfunction

    function automatic logic wiper_addr_ok(input logic [3:0] a);
        wiper_addr_ok = (a[3:2] == 2'b00);
    endfunction

    // Sys-domain state read by the link side
    logic                rb_active_ff;
    logic [FB-1:0]       rb_word_ff;

    // ---------------- Link domain (serial clock) ----------------
    logic                link_rst;
    logic [FB-1:0]       shift_ff;
    logic [FB-1:0]       nxt_shift;
    logic [CB-1:0]       cnt_ff;
    logic [CB-1:0]       nxt_cnt;
    logic [CB-1:0]       cnt_gray_ff;
    logic [PB-1:0]       nxt_pos;
    logic                nxt_sdo;

    // Serial clock only runs in frames; reset settles on its first edges
    qwd_sync #(.W(1), .RST_VAL(1'b0)) u_link_rst (
        .clk (sclk),
        .rst (1'b0),
        .d   (rst),
        .q   (link_rst)
    );

    assign nxt_shift = {shift_ff[FB-2:0], sdi};
    assign nxt_cnt   = cnt_ff + {{(CB-1){1'b0}}, 1'b1};
    assign nxt_pos   = nxt_cnt[PB-1:0];

    // Readback word and flag change only while select is high, so they
    // are settled long before the first serial edge of the next frame.
    always_comb begin
        if (rb_active_ff && nxt_pos != '0) begin
            nxt_sdo = rb_word_ff[4'hF - nxt_pos];
        end else begin
            nxt_sdo = nxt_shift[FB-1];
        end
    end

    always_ff @(posedge sclk) begin
        if (link_rst) begin
            shift_ff <= '0;
        end else if (!cs_n) begin
            shift_ff <= nxt_shift;
        end
    end

    // Bit counter, never cleared between frames, advances only while select is low; gray coded for the sys domain
    always_ff @(posedge sclk) begin
        if (link_rst) begin
            cnt_ff      <= '0;
            cnt_gray_ff <= '0;
        end else if (!cs_n) begin
            cnt_ff      <= nxt_cnt;
            cnt_gray_ff <= bin2gray(nxt_cnt);
        end
    end

    // Open drain: enable low pulls the line low for a zero bit
    always_ff @(posedge sclk) begin
        if (link_rst) begin
            sdo_oe_n <= 1'b1;
        end else if (!cs_n) begin
            sdo_oe_n <= nxt_sdo;
        end
    end

    // ---------------- System domain ----------------
    logic                cs_n_sync;
    logic                cs_n_prev_ff;
    logic [CB-1:0]       cnt_gray_sync;
    logic [FB-1:0]       word_sync;
    logic [CB-1:0]       cnt_now;
    logic [CB-1:0]       start_cnt_ff;
    logic [CB-1:0]       nbits;
    logic                frame_begin;
    logic                frame_end;
    logic                new_go;
    logic                rep_go;
    logic                exec_go;
    qwd_frame_t          exec_frame;
    qwd_frame_t          last_frame_ff;
    logic                last_valid_ff;
    qwd_pstate_t         pstate_ff;
    qwd_pstate_t         nxt_pstate;
    logic [`QWD_NV_BITS-1:0] nv_ff [ND];
    qwd_wop_t            wop [NW];
    qwd_wiper_t          load_val [NW];
    qwd_wiper_t          alu_out [NW];
    logic [1:0]          waddr;
    logic                waddr_ok;

    qwd_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (cs_n),
        .q   (cs_n_sync)
    );

    qwd_sync #(.W(CB), .RST_VAL('0)) u_cnt_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (cnt_gray_ff),
        .q   (cnt_gray_sync)
    );

    // Shift register is static while select is high
    qwd_sync #(.W(FB), .RST_VAL('0)) u_word_sync (
        .clk (clk_sys),
        .rst (rst),
        .d   (shift_ff),
        .q   (word_sync)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cs_n_prev_ff <= 1'b1;
        end else begin
            cs_n_prev_ff <= cs_n_sync;
        end
    end

    assign frame_begin = cs_n_prev_ff && !cs_n_sync;
    assign frame_end   = !cs_n_prev_ff && cs_n_sync;
    assign cnt_now     = gray2bin(cnt_gray_sync);
    assign nbits       = cnt_now - start_cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_cnt_ff <= '0;
        end else if (frame_begin) begin
            start_cnt_ff <= cnt_now;
        end
    end

    // Whole frames run once select rises; bit counts not a multiple of 16 are dropped
    assign new_go  = frame_end && nbits != '0 &&
                     nbits[PB-1:0] == '0;
    assign rep_go  = frame_end && nbits == '0 && last_valid_ff &&
                     pstate_ff != QWD_PS_PRESET;
    assign exec_go = new_go || rep_go;
    assign exec_frame = new_go ? qwd_frame_t'(word_sync) : last_frame_ff;
    assign waddr    = exec_frame.addr[1:0];
    assign waddr_ok = wiper_addr_ok(exec_frame.addr);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_frame_ff <= '0;
            last_valid_ff <= 1'b0;
        end else if (new_go) begin
            last_frame_ff <= qwd_frame_t'(word_sync);
            last_valid_ff <= 1'b1;
        end
    end

    // Power state
    always_comb begin
        nxt_pstate = pstate_ff;
        unique case (pstate_ff)
            QWD_PS_PRESET: nxt_pstate = QWD_PS_IDLE;
            QWD_PS_IDLE, QWD_PS_READPROG: begin
                if (exec_go && exec_frame.cmd == QWD_RESTORE && waddr_ok) begin
                    nxt_pstate = QWD_PS_READPROG;
                end else if (exec_go && exec_frame.cmd == QWD_NOP) begin
                    nxt_pstate = QWD_PS_IDLE;
                end
            end
            default: nxt_pstate = QWD_PS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pstate_ff       <= QWD_PS_PRESET;
            read_prog_state <= 1'b0;
        end else begin
            pstate_ff       <= nxt_pstate;
            read_prog_state <= (nxt_pstate == QWD_PS_READPROG);
        end
    end

    // Per-wiper operation select
    always_comb begin
        for (int i = 0; i < NW; i++) begin
            logic hit;
            hit         = waddr_ok && waddr == 2'(i);
            wop[i]      = QWD_WOP_HOLD;
            load_val[i] = nv_ff[i][`QWD_WIPER_BITS-1:0];
            if (pstate_ff == QWD_PS_PRESET) begin
                wop[i] = QWD_WOP_LOAD;
            end else if (exec_go) begin
                unique case (exec_frame.cmd)
                    QWD_RESTORE:    if (hit) wop[i] = QWD_WOP_LOAD;
                    QWD_RELOAD_ALL: wop[i] = QWD_WOP_LOAD;
                    QWD_WRITE_WIPER: begin
                        load_val[i] = exec_frame.data[`QWD_WIPER_BITS-1:0];
                        if (hit) wop[i] = QWD_WOP_LOAD;
                    end
                    QWD_SHR_ONE: if (hit) wop[i] = QWD_WOP_SHR;
                    QWD_SHR_ALL: wop[i] = QWD_WOP_SHR;
                    QWD_DEC_ONE: if (hit) wop[i] = QWD_WOP_DEC;
                    QWD_DEC_ALL: wop[i] = QWD_WOP_DEC;
                    QWD_SHL_ONE: if (hit) wop[i] = QWD_WOP_SHL;
                    QWD_SHL_ALL: wop[i] = QWD_WOP_SHL;
                    QWD_INC_ONE: if (hit) wop[i] = QWD_WOP_INC;
                    QWD_INC_ALL: wop[i] = QWD_WOP_INC;
                    QWD_NOP, QWD_STORE_WIPER, QWD_STORE_NV,
                    QWD_READ_NV, QWD_READ_WIPER: wop[i] = QWD_WOP_HOLD;
                endcase
            end
        end
    end

    for (genvar g = 0; g < NW; g++) begin : g_alu
        qwd_wiper_alu u_alu (
            .op       (wop[g]),
            .cur      (wiper_register.pos[g]),
            .load_val (load_val[g]),
            .result   (alu_out[g])
        );
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wiper_register <= '0;
        end else begin
            for (int i = 0; i < NW; i++) begin
                wiper_register.pos[i] <= alu_out[i];
            end
        end
    end

    // Nonvolatile store; write time is not modelled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < ND; i++) begin
                nv_ff[i] <= nv_reset(i);
            end
        end else if (exec_go) begin
            if (exec_frame.cmd == QWD_STORE_WIPER && waddr_ok) begin
                nv_ff[waddr] <= {2'b00, wiper_register.pos[waddr]};
            end else if (exec_frame.cmd == QWD_STORE_NV) begin
                nv_ff[exec_frame.addr] <= exec_frame.data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latched_output_one <= 1'b1;
            latched_output_two <= 1'b1;
            sdo_out            <= 1'b0;
        end else begin
            latched_output_one <=
                nv_ff[`QWD_NV_OUT_ADDR][`QWD_OUT_ONE_BIT];
            latched_output_two <=
                nv_ff[`QWD_NV_OUT_ADDR][`QWD_OUT_TWO_BIT];
            sdo_out            <= 1'b0;
        end
    end

    // Readback armed for exactly the frame after a read command
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rb_active_ff <= 1'b0;
            rb_word_ff   <= '0;
        end else if (exec_go) begin
            rb_active_ff <= 1'b0;
            if (exec_frame.cmd == QWD_READ_NV) begin
                rb_active_ff <= 1'b1;
                rb_word_ff   <= {exec_frame.cmd, exec_frame.addr,
                                 nv_ff[exec_frame.addr]};
            end else if (exec_frame.cmd == QWD_READ_WIPER && waddr_ok) begin
                rb_active_ff <= 1'b1;
                rb_word_ff   <= {exec_frame.cmd, exec_frame.addr, 2'b00,
                                 wiper_register.pos[waddr]};
            end
        end else if (frame_end) begin
            rb_active_ff <= 1'b0;
        end
    end

endmodule // qwd_decoder

`default_nettype wire

// ==== verilog/qwd_defs.svh ====
`ifndef QWD_DEFS_SVH
`define QWD_DEFS_SVH

// Serial frame and link counter
`define QWD_FRAME_BITS   16
`define QWD_CNT_BITS     6
`define QWD_POS_BITS     4

// Wiper and nonvolatile store geometry
`define QWD_WIPER_BITS   6
`define QWD_NUM_WIPERS   4
`define QWD_NV_DEPTH     16
`define QWD_NV_BITS      8

// Nonvolatile store layout
`define QWD_NV_OUT_ADDR  4'h4
`define QWD_OUT_ONE_BIT  0
`define QWD_OUT_TWO_BIT  1

// Values the store holds after reset
`define QWD_NV_WIPER_RST 8'h20
`define QWD_NV_OUT_RST   8'h03
`define QWD_NV_USER_RST  8'hFF

// Wiper code limits
`define QWD_WIPER_ZERO   6'h00
`define QWD_WIPER_ONE    6'h01
`define QWD_WIPER_MID    6'h20
`define QWD_WIPER_FULL   6'h3F

`endif

// ==== verilog/qwd_pkg.sv ====
`default_nettype none
`include "qwd_defs.svh"

package qwd_pkg;

    // Declared in code order, so each name takes its frame encoding
    typedef enum logic [3:0] {
        QWD_NOP,
        QWD_RESTORE,
        QWD_STORE_WIPER,
        QWD_STORE_NV,
        QWD_SHR_ONE,
        QWD_SHR_ALL,
        QWD_DEC_ONE,
        QWD_DEC_ALL,
        QWD_RELOAD_ALL,
        QWD_READ_NV,
        QWD_READ_WIPER,
        QWD_WRITE_WIPER,
        QWD_SHL_ONE,
        QWD_SHL_ALL,
        QWD_INC_ONE,
        QWD_INC_ALL
    } qwd_cmd_t;

    typedef struct packed {
        qwd_cmd_t   cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } qwd_frame_t;

    typedef logic [`QWD_WIPER_BITS-1:0] qwd_wiper_t;

    typedef struct packed {
        qwd_wiper_t [`QWD_NUM_WIPERS-1:0] pos;
    } qwd_wipers_t;

    typedef enum logic [2:0] {
        QWD_WOP_HOLD,
        QWD_WOP_LOAD,
        QWD_WOP_SHR,
        QWD_WOP_SHL,
        QWD_WOP_DEC,
        QWD_WOP_INC
    } qwd_wop_t;

    typedef enum logic [1:0] {
        QWD_PS_PRESET,
        QWD_PS_IDLE,
        QWD_PS_READPROG
    } qwd_pstate_t;

endpackage : qwd_pkg

`default_nettype wire

// ==== verilog/qwd_sync.sv ====
`default_nettype none
`include "qwd_defs.svh"

module qwd_sync #(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule // qwd_sync

`default_nettype wire

// ==== verilog/qwd_wiper_alu.sv ====
`default_nettype none
`include "qwd_defs.svh"

module qwd_wiper_alu (
    input  wire qwd_pkg::qwd_wop_t   op,
    input  wire qwd_pkg::qwd_wiper_t cur,
    input  wire qwd_pkg::qwd_wiper_t load_val,
    output qwd_pkg::qwd_wiper_t      result
);
    import qwd_pkg::*;

    always_comb begin
        result = cur;
        unique case (op)
            QWD_WOP_HOLD: result = cur;
            QWD_WOP_LOAD: result = load_val;
            QWD_WOP_SHR:  result = cur >> 1;
            QWD_WOP_SHL: begin
                // Zero steps to one and upper half jumps to full scale
                if (cur == `QWD_WIPER_ZERO) begin
                    result = `QWD_WIPER_ONE;
                end else if (cur >= `QWD_WIPER_MID) begin
                    result = `QWD_WIPER_FULL;
                end else begin
                    result = cur << 1;
                end
            end
            QWD_WOP_DEC: begin
                if (cur != `QWD_WIPER_ZERO) begin
                    result = cur - `QWD_WIPER_ONE;
                end
            end
            QWD_WOP_INC: begin
                if (cur != `QWD_WIPER_FULL) begin
                    result = cur + `QWD_WIPER_ONE;
                end
            end
            default: result = cur;
        endcase
    end

endmodule // qwd_wiper_alu

`default_nettype wire

// ==== testbench/qwd_decoder_monitor.sv ====
`default_nettype none
`include "qwd_defs.svh"
module qwd_decoder_monitor (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 sclk,
    input wire logic                 cs_n,
    input wire logic                 sdo_out,
    input wire logic                 sdo_oe_n,
    input wire qwd_pkg::qwd_wipers_t wiper_register,
    input wire logic                 latched_output_one,
    input wire logic                 latched_output_two,
    input wire logic                 read_prog_state
);
    timeunit 1ns;
    timeprecision 100ps;
    import qwd_pkg::*;
    // Results must wait for the select synchroniser, so count high samples
    logic [3:0] hi_cnt_ff = 4'h0;
    always_ff @(posedge clk_sys) begin
        if (!cs_n) begin
            hi_cnt_ff <= 4'h0;
        end else if (hi_cnt_ff != 4'hF) begin
            hi_cnt_ff <= hi_cnt_ff + 4'h1;
        end
    end
    reset_outs_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> latched_output_one && latched_output_two
            && !read_prog_state)
        else $error("latched outputs wrong after reset");
    preset_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> ##[1:3] wiper_register == {4{`QWD_WIPER_MID}})
        else $error("wipers not preset from store");
    wiper_late_a: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(wiper_register) |-> cs_n && hi_cnt_ff >= 4'h2)
        else $error("wiper changed before select rose");
    outs_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        !cs_n [*8] |-> $stable({latched_output_one, latched_output_two}))
        else $error("latched outputs moved inside a frame");
    prog_change_a: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(read_prog_state) |-> cs_n)
        else $error("read program state moved inside a frame");
    prog_enter_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(read_prog_state) |-> hi_cnt_ff >= 4'h2)
        else $error("read program state entered too early");
    sdo_frame_a: assert property (@(posedge sclk) disable iff (rst)
        $changed(sdo_oe_n) |-> !$past(cs_n))
        else $error("serial output moved outside a frame");
    sdo_drain_a: assert property (@(posedge sclk) disable iff (rst)
        !sdo_oe_n |-> sdo_out == 1'b0)
        else $error("serial output drives a high level");
endmodule // qwd_decoder_monitor

bind qwd_decoder qwd_decoder_monitor mon_u (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .wiper_register(wiper_register),
    .latched_output_one(latched_output_one),
    .latched_output_two(latched_output_two),
    .read_prog_state(read_prog_state)
);
`default_nettype wire

// ==== testbench/qwd_host_model.sv ====
`default_nettype none
module qwd_host_model (
    output var logic sclk,
    output var logic cs_n,
    output var logic sdi,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time HALF = 32ns;
    logic        sdo_line;
    logic [31:0] rx_ff;
    // Open-drain line with a pull-up: released means high
    assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        rx_ff = '0;
    end
    // Only used around reset; nothing shifts with select high
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
    endtask
    task automatic shift_bits(input logic [31:0] word, input int nbits);
        cs_n = 1'b0;
        #50;
        for (int i = nbits - 1; i >= 0; i--) begin
            sdi = word[i];
            // Sample before the rise, since the device moves its output on it
            #HALF rx_ff = {rx_ff[30:0], sdo_line};
            sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        #HALF cs_n = 1'b1;
        sdi = ~sdi;
        #120;
    endtask
    task automatic send16(input logic [15:0] w);
        shift_bits({16'h0000, w}, 16);
    endtask
    task automatic send32(input logic [31:0] w);
        shift_bits(w, 32);
    endtask
    task automatic pulse();
        cs_n = 1'b0;
        #60 cs_n = 1'b1;
        #120;
    endtask
endmodule // qwd_host_model
`default_nettype wire

// ==== testbench/quad_wiper_serial_command_decoder_tb.sv ====
`default_nettype none
`include "qwd_defs.svh"
module quad_wiper_serial_command_decoder_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import qwd_pkg::*;
    logic        clk_sys, rst, sclk, cs_n, sdi, sdo_out, sdo_oe_n;
    logic        lo1, lo2, rps;
    qwd_wipers_t wipers, ew;
    int          num_errors = 0;
    int          samples_checked = 0;
    // {command, start, result} applied to wiper 2
    localparam logic [15:0] ADJ [9] = '{{4'hE, 6'h3E, 6'h3F},
        {4'hE, 6'h3F, 6'h3F}, {4'h6, 6'h01, 6'h00}, {4'h6, 6'h00, 6'h00},
        {4'hC, 6'h00, 6'h01}, {4'hC, 6'h20, 6'h3F}, {4'hC, 6'h05, 6'h0A},
        {4'h4, 6'h01, 6'h00}, {4'h4, 6'h2B, 6'h15}};
    // {command, wiper3..wiper0} after each all-wiper step
    localparam logic [27:0] ALL [5] = '{
        {4'hF, 6'h02, 6'h21, 6'h01, 6'h3F}, {4'h7, 6'h01, 6'h20, 6'h00, 6'h3E},
        {4'hD, 6'h02, 6'h3F, 6'h01, 6'h3F}, {4'h5, 6'h01, 6'h1F, 6'h00, 6'h1F},
        {4'h7, 6'h00, 6'h1E, 6'h00, 6'h1E}};

    qwd_decoder dut_u (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .wiper_register(wipers),
        .latched_output_one(lo1), .latched_output_two(lo2),
        .read_prog_state(rps)
    );
    qwd_host_model host_u (
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [15:0] w);
        host_u.send16(w);
    endtask
    task automatic chk_rx(input logic [15:0] exp);
        chk("serial out", {8'h00, exp}, {8'h00, host_u.rx_ff[15:0]});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic test_write();
        for (int i = 0; i < 4; i++) begin
            cmd({4'hB, 4'(i), 8'hC1 + 8'(i)});
            ew.pos[i] = 6'h01 + 6'(i);
        end
        chk("write", ew, wipers);
        cmd(16'hB53F);
        cmd(16'h0FFF);
        chk("ignored", ew, wipers);
        $display("write test done");
    endtask
    task automatic test_adjust();
        for (int k = 0; k < 9; k++) begin
            cmd({8'hB2, 2'b00, ADJ[k][11:6]});
            cmd({ADJ[k][15:12], 8'h2F, 4'hF});
            ew.pos[2] = ADJ[k][5:0];
            chk("adjust one", ew, wipers);
        end
        cmd(16'hB03F);
        cmd(16'hB100);
        cmd(16'hB220);
        cmd(16'hB301);
        for (int k = 0; k < 5; k++) begin
            cmd({ALL[k][27:24], 12'hFFF});
            chk("adjust all", ALL[k][23:0], wipers);
        end
        ew = ALL[4][23:0];
        $display("adjust test done");
    endtask
    task automatic test_store();
        cmd(16'hB305);
        cmd(16'h2300);
        cmd(16'hB33A);
        cmd(16'h1300);
        ew.pos[3] = 6'h05;
        chk("restore", ew, wipers);
        chk("prog state", 24'h7, {21'h0, rps, lo2, lo1});
        cmd(16'h0000);
        chk("idle state", 24'h3, {21'h0, rps, lo2, lo1});
        cmd(16'hB000);
        cmd(16'h8000);
        ew = {6'h05, {3{`QWD_WIPER_MID}}};
        chk("reload", ew, wipers);
        $display("store test done");
    endtask
    task automatic test_nv();
        cmd(16'h3402);
        chk("outputs", 24'h2, {21'h0, rps, lo2, lo1});
        cmd(16'h9400);
        cmd(16'h0000);
        chk_rx(16'h9402);
        cmd(16'hA300);
        cmd(16'h0000);
        chk_rx(16'hA305);
        cmd(16'h30E7);
        cmd(16'h8000);
        ew.pos[0] = 6'h27;
        chk("byte store", ew, wipers);
        cmd(16'h0123);
        cmd(16'h0000);
        chk_rx(16'h0123);
        $display("store read test done");
    endtask
    task automatic test_chain();
        host_u.send32(32'hB12A_B015);
        ew.pos[0] = 6'h15;
        chk("chain", ew, wipers);
        chk_rx(16'hB12A);
        host_u.shift_bits(32'h0000_313F, 15);
        cmd(16'hB207);
        ew.pos[2] = 6'h07;
        chk("bad length", ew, wipers);
        cmd(16'hE000);
        host_u.pulse();
        ew.pos[0] = 6'h17;
        chk("repeat", ew, wipers);
        $display("chain test done");
    endtask

    initial begin
        rst = 1'b1;
        host_u.idle_clocks(4);
        @(posedge clk_sys);
        rst <= 1'b0;
        host_u.idle_clocks(3);
        chk("preset", {4{`QWD_WIPER_MID}}, wipers);
        chk("reset outs", 24'h3, {21'h0, rps, lo2, lo1});
        $display("reset test done");
        test_write();
        test_adjust();
        test_store();
        test_nv();
        test_chain();
        tally_and_finish();
    end
    initial begin
        #200us;
        num_errors++;
        $display("BAD run end expected finish seen hang");
        tally_and_finish();
    end
endmodule // quad_wiper_serial_command_decoder_tb
`default_nettype wire
